// ---- rtl/trce_consts.vh ----
`ifndef TRCE_CONSTS_VH
`define TRCE_CONSTS_VH
// digits per word
`define TRCE_DIGITS 9
// clock cycles per encoder clock period (oscillator stand-in)
`define TRCE_OSC_DIV 16
// gap counts take a data period as 8 encoder clocks; each pulse runs 5 (counts 0 to 4)
`define TRCE_PULSE_CLKS 4
`define TRCE_SHORT_HIGH 1
`define TRCE_LONG_HIGH 3
// idle gap between words, in data periods
`define TRCE_GAP_PERIODS 3
// gap after a word pair before a repeat, in data periods
`define TRCE_END_PERIODS 4
// probe settle time per phase, in encoder clocks
`define TRCE_PROBE_CLKS 2
// digit codes
`define TRCE_DIG_LOW 2'b00
`define TRCE_DIG_HIGH 2'b01
`define TRCE_DIG_OPEN 2'b10
`endif

// ---- rtl/trce_pulse_gen.v ----
`include "trce_consts.vh"
// ----------------------------------------
// one pulse: high for hiLen clocks then low
// ----------------------------------------
module trce_pulse_gen (
  // clock and reset
  input wire clk,
  input wire rst,
  // control
  input wire tick,
  input wire start,
  input wire isLong,
  // status
  output wire busy,
  output reg pulseOut
);
  reg [2:0] cnt_q;
  reg active_q;
  reg long_q;
  // start kept out of busy: the caller gates start on busy, so folding it in would loop
  assign busy = active_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 3'h0;
      active_q <= 1'b0;
      long_q <= 1'b0;
      pulseOut <= 1'b0;
    end else if (start) begin
      cnt_q <= 3'h0;
      active_q <= 1'b1;
      long_q <= isLong;
      pulseOut <= 1'b0;
    end else if (active_q && tick) begin
      // long pulse three clocks high, short one clock
      pulseOut <= (cnt_q < (long_q ? 3'd`TRCE_LONG_HIGH : 3'd`TRCE_SHORT_HIGH));
      if (cnt_q == 3'd`TRCE_PULSE_CLKS) begin
        active_q <= 1'b0;
        pulseOut <= 1'b0;
      end else begin
        cnt_q <= cnt_q + 3'h1;
      end
    end
  end
endmodule

// ---- rtl/trce_encoder.v ----
`include "trce_consts.vh"
module trce_encoder #(
  parameter DIGITS = `TRCE_DIGITS,
  parameter OSC_DIV = `TRCE_OSC_DIV
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // send request pin, with pull-up enable out
  input wire sendRequestN,
  output wire requestPullUp,
  // digit pins as weak-drive tristate
  input wire [DIGITS-1:0] digitIn,
  output reg [DIGITS-1:0] digitOut,
  output reg [DIGITS-1:0] digitOe,
  // serial code and oscillator state
  output reg codeOut,
  output wire oscRunning
);
  localparam S_IDLE = 7'b0000001;
  localparam S_PROBH = 7'b0000010;
  localparam S_PROBL = 7'b0000100;
  localparam S_SYM1 = 7'b0001000;
  localparam S_SYM2 = 7'b0010000;
  localparam S_GAP = 7'b0100000;
  localparam S_END = 7'b1000000;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  reg reqS1_q, reqS2_q;
  reg [DIGITS-1:0] digS1_q, digS2_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reqS1_q <= 1'b1;
      reqS2_q <= 1'b1;
      digS1_q <= {DIGITS{1'b0}};
      digS2_q <= {DIGITS{1'b0}};
    end else begin
      reqS1_q <= sendRequestN;
      reqS2_q <= reqS1_q;
      digS1_q <= digitIn;
      digS2_q <= digS1_q;
    end
  end
  assign requestPullUp = 1'b1;

  // ----------------------------------------
  // encoder clock divider
  // ----------------------------------------
  reg [6:0] state_q;
  reg [7:0] div_q;
  wire tick = (div_q == OSC_DIV - 1);
  assign oscRunning = (state_q != S_IDLE);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      div_q <= 8'h0;
    end else if (!oscRunning || tick) begin
      div_q <= 8'h0;
    end else begin
      div_q <= div_q + 8'h1;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  function [1:0] classify;
    input sawHigh;
    input sawLow;
    begin
      if (sawHigh && sawLow) begin
        classify = `TRCE_DIG_OPEN;
      end else if (sawHigh) begin
        classify = `TRCE_DIG_HIGH;
      end else begin
        classify = `TRCE_DIG_LOW;
      end
    end
  endfunction

  reg [3:0] digIdx_q;
  reg [3:0] wait_q;
  reg [5:0] gapCnt_q;
  reg secondWord_q;
  reg highSeen_q;
  reg [1:0] digit_q;
  reg pulseStart;
  reg pulseLong;
  wire pulseBusy;
  wire pulseOut;
  localparam integer GAP_TICKS = `TRCE_GAP_PERIODS * 8;
  localparam integer END_TICKS = `TRCE_END_PERIODS * 8;
  wire [5:0] gapLen = secondWord_q ? END_TICKS[5:0] : GAP_TICKS[5:0];

  trce_pulse_gen u_pulse (
    .clk(clk),
    .rst(rst),
    .tick(tick),
    .start(pulseStart),
    .isLong(pulseLong),
    .busy(pulseBusy),
    .pulseOut(pulseOut)
  );

  always @* begin
    pulseStart = 1'b0;
    pulseLong = 1'b0;
    if (state_q == S_PROBL && tick && wait_q == `TRCE_PROBE_CLKS) begin
      pulseStart = 1'b1;
      pulseLong = (classify(highSeen_q, ~digS2_q[digIdx_q]) != `TRCE_DIG_LOW);
    end else if (state_q == S_SYM1 && !pulseBusy) begin
      // second pulse long only for high
      pulseStart = 1'b1;
      pulseLong = (digit_q == `TRCE_DIG_HIGH);
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= S_IDLE;
      digIdx_q <= 4'h0;
      wait_q <= 4'h0;
      gapCnt_q <= 6'h0;
      secondWord_q <= 1'b0;
      highSeen_q <= 1'b0;
      digit_q <= `TRCE_DIG_LOW;
      digitOut <= {DIGITS{1'b0}};
      digitOe <= {DIGITS{1'b0}};
      codeOut <= 1'b0;
    end else begin
      codeOut <= pulseOut;
      case (state_q)
        S_IDLE: begin
          digitOe <= {DIGITS{1'b0}};
          if (!reqS2_q) begin
            state_q <= S_PROBH;
            digIdx_q <= 4'h0;
            secondWord_q <= 1'b0;
            wait_q <= 4'h0;
          end
        end
        S_PROBH: begin
          digitOe <= {{(DIGITS-1){1'b0}}, 1'b1} << digIdx_q;
          digitOut <= {DIGITS{1'b1}};
          if (tick) begin
            if (wait_q == `TRCE_PROBE_CLKS) begin
              highSeen_q <= digS2_q[digIdx_q];
              wait_q <= 4'h0;
              state_q <= S_PROBL;
            end else begin
              wait_q <= wait_q + 4'h1;
            end
          end
        end
        S_PROBL: begin
          digitOut <= {DIGITS{1'b0}};
          if (tick) begin
            if (wait_q == `TRCE_PROBE_CLKS) begin
              digit_q <= classify(highSeen_q, ~digS2_q[digIdx_q]);
              digitOe <= {DIGITS{1'b0}};
              wait_q <= 4'h0;
              state_q <= S_SYM1;
            end else begin
              wait_q <= wait_q + 4'h1;
            end
          end
        end
        S_SYM1: begin
          if (!pulseBusy) begin
            state_q <= S_SYM2;
          end
        end
        S_SYM2: begin
          if (!pulseBusy) begin
            if (digIdx_q == DIGITS - 1) begin
              digIdx_q <= 4'h0;
              gapCnt_q <= 6'h0;
              state_q <= S_GAP;
            end else begin
              digIdx_q <= digIdx_q + 4'h1;
              state_q <= S_PROBH;
            end
          end
        end
        S_GAP: begin
          if (tick) begin
            if (gapCnt_q == gapLen - 6'h1) begin
              state_q <= secondWord_q ? S_END : S_PROBH;
              secondWord_q <= ~secondWord_q;
            end else begin
              gapCnt_q <= gapCnt_q + 6'h1;
            end
          end
        end
        S_END: begin
          state_q <= reqS2_q ? S_IDLE : S_PROBH;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// ---- verification/trce_encoder_sva.sv ----
module trce_encoder_sva #(parameter DIGITS = 9, parameter OSC_DIV = 16) (
  // clock and reset
  input wire clk,
  input wire rst,
  // pins
  input wire sendRequestN,
  input wire requestPullUp,
  input wire [DIGITS-1:0] digitOut,
  input wire [DIGITS-1:0] digitOe,
  input wire codeOut,
  input wire oscRunning
);
  // ----------------
  // run counters
  // ----------------
  int hiCnt_q;
  int loCnt_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hiCnt_q <= 0;
      loCnt_q <= 0;
    end else begin
      hiCnt_q <= codeOut ? hiCnt_q + 1 : 0;
      loCnt_q <= (oscRunning && !codeOut) ? loCnt_q + 1 : 0;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  pull_up_a: assert property (requestPullUp)
    else $error("pull-up off");
  idle_low_a: assert property (!oscRunning |-> !codeOut)
    else $error("output high while idle");
  idle_probe_a: assert property (!oscRunning |-> digitOe == 0)
    else $error("probing while idle");
  one_probe_a: assert property ($onehot0(digitOe))
    else $error("several lines probed");
  start_seen_a: assert property ($fell(sendRequestN) && !oscRunning |-> ##[1:4] oscRunning)
    else $error("no start");
  wake_cause_a: assert property ($rose(oscRunning) |-> !$past(sendRequestN, 3) || !$past(sendRequestN, 4))
    else $error("woke without request");
  pulse_len_a: assert property ($fell(codeOut) |-> hiCnt_q == OSC_DIV || hiCnt_q == 3 * OSC_DIV)
    else $error("bad pulse width");
  gap_bound_a: assert property (loCnt_q < 1000)
    else $error("silent too long");
  probe_high_a: assert property ($rose(|digitOe) |-> |(digitOut & digitOe))
    else $error("probe not high first");
  cover property ($fell(codeOut) && hiCnt_q == 3 * OSC_DIV);
  cover property (loCnt_q == 384);
  cover property ($rose(oscRunning));
endmodule
bind trce_encoder trce_encoder_sva #(.DIGITS(DIGITS), .OSC_DIV(OSC_DIV)) sva (.clk, .rst, .sendRequestN,
  .requestPullUp, .digitOut, .digitOe, .codeOut, .oscRunning);

// ---- verification/trce_pin_model.sv ----
module trce_pin_model (
  // weak drive from the encoder
  input wire [8:0] drv,
  input wire [8:0] oe,
  // per line: 00 low, 01 high, 1x open
  input wire [17:0] tie,
  output logic [8:0] lvl
);
  // open line has no keeper, so it flips once released
  // three states per line
  always_comb begin
    for (int i = 0; i < 9; i++) begin
      lvl[i] = tie[2*i+1] ? (oe[i] ? drv[i] : ~drv[i]) : tie[2*i];
    end
  end
endmodule

// ---- verification/test_trinary_remote_code_encoder.sv ----
module test_trinary_remote_code_encoder;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0;
  logic rst = 1;
  logic sendRequestN = 1;
  logic [17:0] tie = '0;
  wire [8:0] digitIn;
  wire [8:0] digitOut;
  wire [8:0] digitOe;
  wire codeOut;
  wire oscRunning;
  wire requestPullUp;
  int fail_count = 0;
  int n_tests = 0;
  initial forever #12.5 clk = ~clk;
  trce_encoder uut (.clk, .rst, .sendRequestN, .requestPullUp, .digitIn, .digitOut, .digitOe, .codeOut,
    .oscRunning);
  trce_pin_model pins (.drv(digitOut), .oe(digitOe), .tie(tie), .lvl(digitIn));
  // ----------------
  // helpers
  // ----------------
  task automatic chk(input bit ok, input string m);
    n_tests++;
    if (!ok) begin
      fail_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic pulse(output int hi, output int lo);
    hi = 0;
    lo = 0;
    while (codeOut !== 1'b1 && lo < 2000) begin
      @(negedge clk);
      lo++;
    end
    while (codeOut === 1'b1 && hi < 100) begin
      @(negedge clk);
      hi++;
    end
  endtask
  // long pulse first unless tied low, long second only if tied high
  task automatic word_pair(input logic [17:0] t, input bit skipFirst);
    int hi;
    int lo;
    logic [1:0] d;
    for (int k = 0; k < 36; k++) begin
      d = t[2*((k/2)%9) +: 2];
      pulse(hi, lo);
      if (k == 18) chk(lo >= 384, "word gap short");
      if (k >= 18 || !skipFirst) chk(hi > 0 && (hi > 32) == (k % 2 ? d == 2'h1 : d != 2'h0), "symbol");
    end
  endtask
  task automatic wait_idle;
    int n = 0;
    while (oscRunning !== 1'b0 && n < 8000) begin
      @(negedge clk);
      n++;
    end
    chk(n < 8000, "did not stop");
    repeat (50) @(negedge clk) chk(codeOut === 1'b0, "not resting low");
  endtask
  // ----------------
  // scenarios
  // ----------------
  task automatic t_short;
    chk(oscRunning === 1'b0 && codeOut === 1'b0, "active while off");
    chk(requestPullUp === 1'b1, "request pull-up off");
    @(posedge clk);
    tie <= 18'h24924;
    sendRequestN <= 1'b0;
    repeat (3) @(posedge clk);
    sendRequestN <= 1'b1;
    word_pair(18'h24924, 1'b1);
    wait_idle;
    $display("short request test done");
  endtask
  task automatic t_hold;
    @(posedge clk);
    tie <= 18'h12492;
    sendRequestN <= 1'b0;
    word_pair(18'h12492, 1'b0);
    word_pair(18'h12492, 1'b0);
    @(posedge clk);
    sendRequestN <= 1'b1;
    wait_idle;
    $display("held request test done");
  endtask
  task automatic test_done;
    $display("%0d checks, %0d mismatches", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_short;
    t_hold;
    test_done;
  end
  initial begin
    #(40000 * 25);
    fail_count++;
    test_done;
  end
endmodule
